/* phase_select_map.vh */
// Constants for the phase select serial port
`ifndef PHASE_SELECT_MAP_VH
`define PHASE_SELECT_MAP_VH

// Word layout
`define WORD_WIDTH          20
`define NUM_CHANNELS        4
`define PHASE_WIDTH         4
`define ENABLE_LSB          16
`define ENABLE_MSB          19
`define PHASE_MSB           15
`define PHASE_LSB           0
`define ANGLE_WIDTH         10

// Reset and special values
`define WORD_ZERO           20'h00000
`define WORD_QUICK_TEST     20'hf0000
`define ENABLES_ALL_OFF     4'h0
`define ANGLE_ZERO          40'h0000000000
`define LO_QUAD_RESET       2'h0
`define LO_QUAD_STEP        2'h1

// Phase step of 22.5 degrees in half-degree units
`define PHASE_STEP_HALF_DEG 10'h02d

// Pin synchroniser lanes
`define PIN_COUNT           7
`define PIN_SCLK            0
`define PIN_CS_N            1
`define PIN_SDI             2
`define PIN_CLEAR           3
`define PIN_QUICK           4
`define PIN_LO_SYNC         5
`define PIN_LO_4X           6
`define PINS_RESET          7'h00
`define PINS_IDLE           7'h02

// Timing
`define CLK_PERIOD_NS       5
`define BIAS_SETTLE_NS      10000
`define SETTLE_CNT_WIDTH    12
`define SETTLE_CNT_ZERO     12'h000
`define SETTLE_CNT_ONE      12'h001

`endif

/* phase_select_serial_port.v */
// Serial control port with latch, power-down and LO divider sync
//
// Operation
// - Four-wire port: 20-bit shift register followed by 20-bit latch.
// - Words enter MSB first; contents move toward the LSB each shift.
// - Latch captures register contents on chip select rising edge.
// - Shifting is allowed anytime and leaves the latch untouched.
// - Serial input is sampled on every serial clock rising edge while the clear pin is low.
// - Serial output changes on serial clock rising edge, feeding next device.
// - Latched word enables channels and applies their phase codes.
// - All enables zero powers down everything except the serial port.
// - Power returns when CS latches a word with any enable set.
// - Clear pin zeroes shift register and latch, powering all down.
// - Clear high then quick-test pin high (before any CS rise): all channels on, phase 0000.
// - Sync pin halts LO dividers without stopping the 4x LO input.
// - Dividers restart on the next 4x LO rising edge after sync falls.
// - Unsynced divider starts in any quadrant; I and Q stay 90 apart.
// - Phase shift equals code times 22.5 degrees.
`include "phase_select_map.vh"
`default_nettype none

module phase_select_serial_port #(
  parameter integer SETTLE_CYCLES =
    (`BIAS_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // System
  input  wire                       SYS_CLK_IN,
  input  wire                       RESET_IN,
  // Serial port pins
  input  wire                       SERIAL_CLOCK_IN,
  input  wire                       CHIP_SELECT_N_IN,
  input  wire                       SERIAL_IN_IN,
  output wire                       SERIAL_OUT_OUT,
  // Clear and quick-test pins
  input  wire                       SERIAL_CLEAR_PIN_IN,
  input  wire                       QUICK_TEST_NEG_IN,
  // LO divider pins
  input  wire                       LO_DIVIDER_SYNC_IN,
  input  wire                       QUAD_RATE_LO_INPUT_IN,
  // Channel configuration
  output wire [`WORD_WIDTH-1:0]     CONFIG_WORD_OUT,
  output wire [`NUM_CHANNELS-1:0]   CHANNEL_ENABLE_BIT_OUT,
  output wire [`PHASE_MSB:0]        PHASE_CODE_OUT,
  output wire [4*`ANGLE_WIDTH-1:0]  PHASE_ANGLE_OUT,
  // Power state
  output wire                       POWER_DOWN_OUT,
  output wire                       BIAS_SETTLED_OUT,
  // LO divider state
  output wire                       LO_RUN_OUT,
  output wire [1:0]                 LO_QUADRANT_OUT,
  output wire                       LO_I_OUT,
  output wire                       LO_Q_OUT
);

  // Reverse bit order so the first bit sent lands at the top
  function [`WORD_WIDTH-1:0] reverse_word;
    input [`WORD_WIDTH-1:0] w;
    integer i;
    begin
      reverse_word = `WORD_ZERO;
      for (i = 0; i < `WORD_WIDTH; i = i + 1) begin
        reverse_word[i] = w[`WORD_WIDTH-1-i];
      end
    end
  endfunction

  // Phase angle in half degrees
  function [`ANGLE_WIDTH-1:0] phase_half_deg;
    input [`PHASE_WIDTH-1:0] code;
    reg   [2*`ANGLE_WIDTH-1:0] prod;
    begin
      prod = {16'h0000, code} * {10'h000, `PHASE_STEP_HALF_DEG};
      phase_half_deg = prod[`ANGLE_WIDTH-1:0];
    end
  endfunction

  localparam [`SETTLE_CNT_WIDTH-1:0] SETTLE_LOAD =
    SETTLE_CYCLES[`SETTLE_CNT_WIDTH-1:0];

  // Pin synchronisers
  reg  [`PIN_COUNT-1:0]    sync1_ff;
  reg  [`PIN_COUNT-1:0]    sync2_ff;
  reg  [`PIN_COUNT-1:0]    sync3_ff;
  reg  [`PIN_COUNT-1:0]    pin_ff;
  reg  [`PIN_COUNT-1:0]    pin_prev_ff;
  wire [`PIN_COUNT-1:0]    pin_raw;
  wire [`PIN_COUNT-1:0]    nxt_pin;
  wire                     sclk_rise;
  wire                     cs_rise;
  wire                     lo4x_rise;
  wire                     clear_lvl;
  wire                     quick_lvl;
  wire                     sync_lvl;
  wire                     sdi_lvl;

  // Serial datapath
  reg  [`WORD_WIDTH-1:0]   shift_ff;
  reg  [`WORD_WIDTH-1:0]   nxt_shift;
  reg                      sdo_ff;
  reg                      nxt_sdo;
  reg  [`WORD_WIDTH-1:0]   latch_ff;
  reg  [`WORD_WIDTH-1:0]   nxt_latch;
  reg                      armed_ff;
  reg                      nxt_armed;

  // Decoded configuration
  reg  [4*`ANGLE_WIDTH-1:0] angle_ff;
  reg  [4*`ANGLE_WIDTH-1:0] nxt_angle;
  wire                      all_off;
  integer                   k;

  // Power and settling
  reg  [`SETTLE_CNT_WIDTH-1:0] settle_ff;
  reg  [`SETTLE_CNT_WIDTH-1:0] nxt_settle;
  reg                          pdown_ff;

  // LO divider
  reg  [1:0]               quad_ff;
  reg  [1:0]               nxt_quad;
  reg                      run_ff;
  reg                      nxt_run;
  reg                      lo_i_ff;
  reg                      lo_q_ff;

  assign pin_raw[`PIN_SCLK]    = SERIAL_CLOCK_IN;
  assign pin_raw[`PIN_CS_N]    = CHIP_SELECT_N_IN;
  assign pin_raw[`PIN_SDI]     = SERIAL_IN_IN;
  assign pin_raw[`PIN_CLEAR]   = SERIAL_CLEAR_PIN_IN;
  assign pin_raw[`PIN_QUICK]   = QUICK_TEST_NEG_IN;
  assign pin_raw[`PIN_LO_SYNC] = LO_DIVIDER_SYNC_IN;
  assign pin_raw[`PIN_LO_4X]   = QUAD_RATE_LO_INPUT_IN;

  // A level changes only once stages two and three agree
  assign nxt_pin = (sync2_ff & sync3_ff) |
                   (pin_ff & (sync2_ff ^ sync3_ff));

  always @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      sync1_ff    <= `PINS_IDLE;
      sync2_ff    <= `PINS_IDLE;
      sync3_ff    <= `PINS_IDLE;
      pin_ff      <= `PINS_IDLE;
      pin_prev_ff <= `PINS_IDLE;
    end else begin
      sync1_ff    <= pin_raw;
      sync2_ff    <= sync1_ff;
      sync3_ff    <= sync2_ff;
      pin_ff      <= nxt_pin;
      pin_prev_ff <= pin_ff;
    end
  end

  assign sclk_rise = pin_ff[`PIN_SCLK] & ~pin_prev_ff[`PIN_SCLK];
  assign cs_rise   = pin_ff[`PIN_CS_N] & ~pin_prev_ff[`PIN_CS_N];
  assign lo4x_rise = pin_ff[`PIN_LO_4X] & ~pin_prev_ff[`PIN_LO_4X];
  assign clear_lvl = pin_ff[`PIN_CLEAR];
  assign quick_lvl = pin_ff[`PIN_QUICK];
  assign sync_lvl  = pin_ff[`PIN_LO_SYNC];
  assign sdi_lvl   = pin_ff[`PIN_SDI];

  // Shift register, serial out and latch
  always @* begin
    nxt_shift = shift_ff;
    nxt_sdo   = sdo_ff;
    nxt_latch = latch_ff;
    nxt_armed = armed_ff;
    if (clear_lvl) begin
      nxt_shift = `WORD_ZERO;
      nxt_sdo   = 1'b0;
      nxt_latch = `WORD_ZERO;
      nxt_armed = 1'b1;
    end else begin
      if (sclk_rise) begin
        // Shifts regardless of chip select
        nxt_shift = {sdi_lvl, shift_ff[`WORD_WIDTH-1:1]};
        nxt_sdo   = shift_ff[0];
      end
      if (cs_rise) begin
        // Captures the contents before any shift in the same cycle
        nxt_latch = reverse_word(shift_ff);
        nxt_armed = 1'b0;
      end else if (armed_ff && quick_lvl) begin
        nxt_latch = `WORD_QUICK_TEST;
      end
    end
  end

  always @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      shift_ff <= `WORD_ZERO;
      sdo_ff   <= 1'b0;
      latch_ff <= `WORD_ZERO;
      armed_ff <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      sdo_ff   <= nxt_sdo;
      latch_ff <= nxt_latch;
      armed_ff <= nxt_armed;
    end
  end

  // Per-channel phase angle
  always @* begin
    nxt_angle = `ANGLE_ZERO;
    for (k = 0; k < `NUM_CHANNELS; k = k + 1) begin
      nxt_angle[k*`ANGLE_WIDTH +: `ANGLE_WIDTH] =
        phase_half_deg(latch_ff[k*`PHASE_WIDTH +: `PHASE_WIDTH]);
    end
  end

  assign all_off =
    (latch_ff[`ENABLE_MSB:`ENABLE_LSB] == `ENABLES_ALL_OFF);

  // Settle counter restarts on each wake
  always @* begin
    nxt_settle = settle_ff;
    if (all_off) begin
      nxt_settle = SETTLE_LOAD;
    end else if (settle_ff != `SETTLE_CNT_ZERO) begin
      nxt_settle = settle_ff - `SETTLE_CNT_ONE;
    end
  end

  always @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      angle_ff  <= `ANGLE_ZERO;
      pdown_ff  <= 1'b1;
      settle_ff <= `SETTLE_CNT_ZERO;
    end else begin
      angle_ff  <= nxt_angle;
      pdown_ff  <= all_off;
      settle_ff <= nxt_settle;
    end
  end

  // LO divide-by-four; quadrant kept through power-down, so unsynced
  // devices may wake in any quadrant
  always @* begin
    nxt_quad = quad_ff;
    nxt_run  = run_ff;
    if (sync_lvl || all_off) begin
      nxt_run = 1'b0;
      if (sync_lvl) begin
        nxt_quad = `LO_QUAD_RESET;
      end
    end else if (lo4x_rise) begin
      nxt_run = 1'b1;
      if (run_ff) begin
        nxt_quad = quad_ff + `LO_QUAD_STEP;
      end
    end
  end

  always @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      quad_ff <= `LO_QUAD_RESET;
      run_ff  <= 1'b0;
      lo_i_ff <= 1'b0;
      lo_q_ff <= 1'b0;
    end else begin
      quad_ff <= nxt_quad;
      run_ff  <= nxt_run;
      // Gray sequence keeps I and Q a quarter period apart
      lo_i_ff <= nxt_run & nxt_quad[1];
      lo_q_ff <= nxt_run & (nxt_quad[1] ^ nxt_quad[0]);
    end
  end

  assign SERIAL_OUT_OUT         = sdo_ff;
  assign CONFIG_WORD_OUT        = latch_ff;
  assign CHANNEL_ENABLE_BIT_OUT = latch_ff[`ENABLE_MSB:`ENABLE_LSB];
  assign PHASE_CODE_OUT         = latch_ff[`PHASE_MSB:`PHASE_LSB];
  assign PHASE_ANGLE_OUT        = angle_ff;
  assign POWER_DOWN_OUT         = pdown_ff;
  assign BIAS_SETTLED_OUT       = ~pdown_ff &
                                  (settle_ff == `SETTLE_CNT_ZERO);
  assign LO_RUN_OUT             = run_ff;
  assign LO_QUADRANT_OUT        = quad_ff;
  assign LO_I_OUT               = lo_i_ff;
  assign LO_Q_OUT               = lo_q_ff;

endmodule

`default_nettype wire

/* phase_select_serial_port_asserts.sv */
// Pin level assertions for the phase select serial port
`default_nettype none
module phase_select_serial_port_asserts (
  input wire logic        SYS_CLK_IN,
  input wire logic        RESET_IN,
  input wire logic        SERIAL_CLOCK_IN,
  input wire logic        CHIP_SELECT_N_IN,
  input wire logic        SERIAL_CLEAR_PIN_IN,
  input wire logic        QUICK_TEST_NEG_IN,
  input wire logic        LO_DIVIDER_SYNC_IN,
  input wire logic        SERIAL_OUT_OUT,
  input wire logic [19:0] CONFIG_WORD_OUT,
  input wire logic [3:0]  CHANNEL_ENABLE_BIT_OUT,
  input wire logic [15:0] PHASE_CODE_OUT,
  input wire logic [39:0] PHASE_ANGLE_OUT,
  input wire logic        POWER_DOWN_OUT,
  input wire logic        LO_RUN_OUT,
  input wire logic [1:0]  LO_QUADRANT_OUT,
  input wire logic        LO_I_OUT,
  input wire logic        LO_Q_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  logic [3:0] cs_age_ff;
  logic [3:0] sck_age_ff;
  // Pin events pass a 4-stage filter, so outputs lag them by a few cycles
  always @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      cs_age_ff  <= 4'hf;
      sck_age_ff <= 4'hf;
    end else begin
      cs_age_ff  <= ($rose(CHIP_SELECT_N_IN) | SERIAL_CLEAR_PIN_IN |
        QUICK_TEST_NEG_IN) ? 4'h0 : cs_age_ff + {3'h0, ~&cs_age_ff};
      sck_age_ff <= ($rose(SERIAL_CLOCK_IN) | SERIAL_CLEAR_PIN_IN) ?
        4'h0 : sck_age_ff + {3'h0, ~&sck_age_ff};
    end
  end
  sequence s_clear_held;
    SERIAL_CLEAR_PIN_IN [*8];
  endsequence
  sequence s_sync_held;
    LO_DIVIDER_SYNC_IN [*7];
  endsequence
  AST_FIELDS: assert property (
    {CHANNEL_ENABLE_BIT_OUT, PHASE_CODE_OUT} == CONFIG_WORD_OUT)
    else $error("fields differ from latched word");
  AST_POWER_DOWN: assert property (
    POWER_DOWN_OUT == ($past(CHANNEL_ENABLE_BIT_OUT) == 4'h0))
    else $error("power down does not follow enables");
  AST_ANGLE: assert property (
    PHASE_ANGLE_OUT[9:0] == $past(PHASE_CODE_OUT[3:0]) * 10'h02d &&
    PHASE_ANGLE_OUT[39:30] == $past(PHASE_CODE_OUT[15:12]) * 10'h02d)
    else $error("phase angle wrong");
  AST_HOLD: assert property (
    $changed(CONFIG_WORD_OUT) |-> cs_age_ff < 4'h8)
    else $error("latch moved without chip select rise");
  AST_SO_EDGE: assert property (
    $changed(SERIAL_OUT_OUT) |-> sck_age_ff < 4'h8)
    else $error("serial out moved without clock rise");
  AST_CLEAR: assert property (
    s_clear_held |-> CONFIG_WORD_OUT == 20'h00000 && !SERIAL_OUT_OUT &&
    POWER_DOWN_OUT)
    else $error("clear did not zero the port");
  AST_SYNC: assert property (
    s_sync_held |-> !LO_RUN_OUT && LO_QUADRANT_OUT == 2'h0)
    else $error("sync did not halt divider");
  AST_QUAD_STEP: assert property (
    LO_RUN_OUT && $past(LO_RUN_OUT) && $changed(LO_QUADRANT_OUT) |->
    LO_QUADRANT_OUT == $past(LO_QUADRANT_OUT) + 2'h1)
    else $error("quadrant skipped");
  AST_IQ: assert property (
    LO_I_OUT == (LO_RUN_OUT & LO_QUADRANT_OUT[1]) &&
    LO_Q_OUT == (LO_RUN_OUT & ^LO_QUADRANT_OUT))
    else $error("I and Q not in quadrature");
  AST_IQ_STEP: assert property (
    LO_RUN_OUT && $past(LO_RUN_OUT) && $changed(LO_QUADRANT_OUT) |->
    $changed(LO_I_OUT) != $changed(LO_Q_OUT))
    else $error("I and Q did not step one at a time");
endmodule
bind phase_select_serial_port phase_select_serial_port_asserts u_chk (.*);
`default_nettype wire

/* serial_master_model.sv */
// Serial master that shifts words into the port
`default_nettype none
module serial_master_model (
  input  wire logic clk_in,
  input  wire logic so_in,
  output var  logic sclk_out,
  output var  logic cs_n_out,
  output var  logic sdi_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [19:0] got = 20'h00000;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out  = 1'b0;
  end
  // Long phases: pins pass a filter of several cycles
  task automatic half();
    repeat (8) @(posedge clk_in);
    #1;
  endtask
  task automatic send20(input logic [19:0] w);
    for (int i = 19; i >= 0; i--) begin
      sdi_out = w[i];
      half();
      sclk_out = 1'b1;
      half();
      got = {got[18:0], so_in};
      sclk_out = 1'b0;
    end
    // Released data line shows no stale bit
    sdi_out = ~sdi_out;
    // Lets eight cycles pass so the next word never rewrites the line at once
    half();
  endtask
  task automatic latch();
    cs_n_out = 1'b0;
    half();
    cs_n_out = 1'b1;
    half();
  endtask
endmodule
`default_nettype wire

/* test_phase_select_serial_port.sv */
// Self-checking bench for the phase select serial port
`default_nettype none
module test_phase_select_serial_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        clr = 1'b0;
  logic        quick = 1'b0;
  logic        sync = 1'b0;
  logic        lo = 1'b0;
  wire         sclk, cs_n, serial_in, so, pd, settled, run, lo_i, lo_q;
  wire  [19:0] cfg;
  wire  [3:0]  en;
  wire  [15:0] ph;
  wire  [39:0] ang;
  wire  [1:0]  quad;
  int          mismatches = 0;
  int          tests_run = 0;
  // Bit 20 is the expected power down, below it the word
  logic [20:0] rows [5] = '{21'h100000, 21'h0f0123, 21'h084567,
                            21'h0289ab, 21'h01cdef};
  phase_select_serial_port #(.SETTLE_CYCLES(20)) dut (
    .SYS_CLK_IN(clk), .RESET_IN(rst), .SERIAL_CLOCK_IN(sclk),
    .CHIP_SELECT_N_IN(cs_n), .SERIAL_IN_IN(serial_in), .SERIAL_OUT_OUT(so),
    .SERIAL_CLEAR_PIN_IN(clr), .QUICK_TEST_NEG_IN(quick),
    .LO_DIVIDER_SYNC_IN(sync), .QUAD_RATE_LO_INPUT_IN(lo),
    .CONFIG_WORD_OUT(cfg), .CHANNEL_ENABLE_BIT_OUT(en),
    .PHASE_CODE_OUT(ph), .PHASE_ANGLE_OUT(ang), .POWER_DOWN_OUT(pd),
    .BIAS_SETTLED_OUT(settled), .LO_RUN_OUT(run),
    .LO_QUADRANT_OUT(quad), .LO_I_OUT(lo_i), .LO_Q_OUT(lo_q));
  serial_master_model m (.clk_in(clk), .so_in(so), .sclk_out(sclk),
    .cs_n_out(cs_n), .sdi_out(serial_in));
  always #2.5 clk = ~clk;
  // Free running 4x LO, never stopped for sync
  always begin
    cyc(5);
    lo = ~lo;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait until lo has just reached the given level
  task automatic lo_edge(input logic lvl);
    int i;
    i = 0;
    while (i < 24 && lo === lvl) begin
      @(posedge clk);
      i++;
    end
    while (i < 24 && lo !== lvl) begin
      @(posedge clk);
      i++;
    end
    if (i == 24) begin
      mismatches++;
      test_done();
    end
  endtask
  task automatic check(input string n, input logic [39:0] s, e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    int t;
    cyc(5);
    check("pd_rst", pd, 40'h1);
    check("cfg_rst", cfg, 40'h0);
    rst = 1'b0;
    foreach (rows[r]) begin
      m.send20(rows[r][19:0]);
      m.latch();
      check("cfg", cfg, rows[r][19:0]);
      check("en", en, rows[r][19:16]);
      check("ph", ph, rows[r][15:0]);
      check("pd", pd, rows[r][20]);
      for (int c = 0; c < 4; c++) begin
        check("ang", ang[c*10 +: 10],
              10'(rows[r][c*4 +: 4]) * 10'h02d);
      end
    end
    // Shifting with chip select high, two words as for a chain
    m.send20(20'h5a5a5);
    check("hold", cfg, rows[4][19:0]);
    // One channel on with phase code zero, ready for the sync check
    m.send20(20'h10000);
    check("chain", m.got, 20'h5a5a5);
    m.latch();
    check("cfg2", cfg, 20'h10000);
    lo_edge(1'b0);
    cyc(1);
    sync = 1'b1;
    cyc(10);
    check("halt", {run, quad}, 3'h0);
    lo_edge(1'b0);
    cyc(1);
    sync = 1'b0;
    for (t = 0; t < 40 && run !== 1'b1; t++) begin
      cyc(1);
    end
    if (t == 40) begin
      mismatches++;
      test_done();
    end
    check("q0", {quad, lo_i, lo_q}, 4'h0);
    lo_edge(1'b1);
    cyc(8);
    check("q1", {quad, lo_i, lo_q}, 4'h5);
    clr = 1'b1;
    cyc(8);
    check("clr", {cfg, so, pd}, 22'h000001);
    clr = 1'b0;
    quick = 1'b1;
    cyc(7);
    check("quick", {cfg, pd}, 21'h1e0000);
    check("bias0", settled, 40'h0);
    cyc(30);
    check("bias1", settled, 40'h1);
    test_done();
  end
endmodule
`default_nettype wire
